// ===== src/pcs_socket.sv
// Per-socket card enable, reset, wait and status signal control.
`timescale 1ns/1ps
`include "pcs_cfg.svh"
//
// Overview of operation
// - Card enables go low in access cycles; first even bytes, second odd.
// - Narrow cards: only the even enable, odd or even chosen by address bit.
// - Card reset output low normally, high to reset the card.
// - Card reset floats unless card seated, powered and interface enabled.
// - Card wait request stalls the running access until released.
// - Memory mode: ready input reports card ready or busy.
// - I/O mode: ready input is the card interrupt request.
// - Both card detect inputs decide card presence.
// - Memory mode: battery inputs report battery dead and battery warning.
// - I/O mode: first battery input signals card status change.
// - Ring enable set: status change input acts as ring indicate.
// - I/O mode: second battery input may be the speaker signal.
// - Second battery input may be a disk activity indicator.
// - Both voltage sense inputs give the card supply voltage.
// - Voltage sense pins may be driven as general purpose strobes.
// - Input acknowledge from the card is ignored.
//
module pcs_socket #(
   parameter int DEB_CYC = `PCS_DEB_CYC
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   // Access cycle request from the window logic.
   input  wire logic        acc_start,
   input  wire logic        acc_word,
   input  wire logic        acc_addr0,
   output logic             acc_busy,
   output logic             acc_done,
   // Card enables and address bit.
   output logic             even_byte_enable_n,
   output logic             odd_byte_enable_n,
   output logic             lowest_address_bit,
   // Card reset.
   output logic             card_reset_out,
   output logic             card_reset_oe,
   // Card status inputs.
   input  wire logic [1:0]  card_present_inputs_n,
   input  wire logic        ready_or_card_irq,
   input  wire logic        card_wait_n,
   input  wire logic        battery_dead_or_status_change,
   input  wire logic        battery_warn_or_audio_or_activity,
   input  wire logic        input_acknowledge_unused_n,
   // Voltage sense pins, also strobes.
   input  wire logic        volt_sense_one_or_strobe_in,
   output logic             volt_sense_one_or_strobe_out,
   input  wire logic        volt_sense_two_or_strobe_in,
   output logic             volt_sense_two_or_strobe_out,
   output logic             volt_sense_oe,
   // Speaker and activity indicator.
   output logic             speaker_out,
   output logic             activity_out
);

   //***********************************************************
   // State and decoded views.
   //***********************************************************

   pcs_pkg::pcs_state_t r_r;
   pcs_pkg::pcs_state_t r_nxt;

   // Synchronised input bits, mode, bus phases, events and clear mask.
   logic       cd_low;
   logic       rdy_s;
   logic       wait_s;
   logic       bvd1_s;
   logic       bvd2_s;
   logic [1:0] vs_s;
   logic       io_mode;
   logic       setup;
   logic       wr;
   logic [5:0] ev;
   logic [5:0] clr;

   // Decoded views of the second synchroniser stage, and the I/O mode bit.
   assign cd_low = (r_r.s2[1:0] == 2'h0);
   assign rdy_s  = r_r.s2[2];
   assign wait_s = ~r_r.s2[3];
   assign bvd1_s = r_r.s2[4];
   assign bvd2_s = r_r.s2[5];
   assign vs_s   = r_r.s2[7:6];
   assign io_mode = r_r.ctrl[`PCS_C_IO];

   // Bus phases; every access completes with no wait state.
   assign setup = psel & ~penable;
   assign wr    = psel & penable & pwrite;

   //***********************************************************
   // Events and next state.
   //***********************************************************

   // Interrupt events from card inputs and the access machine.
   always_comb begin
      ev = 6'h00;
      ev[`PCS_E_DETECT] = (cd_low != r_r.present)
                          & (r_r.deb == 18'(DEB_CYC - 1));
      ev[`PCS_E_READY]  = ~io_mode & rdy_s & ~r_r.rdy_q;
      ev[`PCS_E_CIRQ]   = io_mode & ~rdy_s;
      ev[`PCS_E_STSCHG] = io_mode & ~r_r.ctrl[`PCS_C_RINGEN]
                          & r_r.bvd1_q & ~bvd1_s;
      ev[`PCS_E_RING]   = r_r.ctrl[`PCS_C_RINGEN]
                          & r_r.bvd1_q & ~bvd1_s;
      ev[`PCS_E_DONE]   = r_r.done;
   end

   // Write-one-to-clear mask for the sticky bits.
   assign clr = (wr && paddr == `PCS_A_ICLR) ? pwdata[5:0] : 6'h00;

   // One process computes every next value of the state.
   always_comb begin
      r_nxt = r_r;
      // Two stage synchroniser; input acknowledge is not sampled.
      r_nxt.s1 = {volt_sense_two_or_strobe_in,
                  volt_sense_one_or_strobe_in,
                  battery_warn_or_audio_or_activity,
                  battery_dead_or_status_change,
                  card_wait_n,
                  ready_or_card_irq,
                  card_present_inputs_n};
      r_nxt.s2 = r_r.s1;
      r_nxt.rdy_q  = rdy_s;
      r_nxt.bvd1_q = bvd1_s;

      // Presence changes only after the detects hold a new level
      // for the whole debounce time; contact bounce is filtered.
      if (cd_low == r_r.present) begin
         r_nxt.deb = 18'h00000;
      end else if (r_r.deb == 18'(DEB_CYC - 1)) begin
         r_nxt.deb     = 18'h00000;
         r_nxt.present = cd_low;
      end else begin
         r_nxt.deb = r_r.deb + 18'h00001;
      end

      // Register writes take effect in the access phase.
      if (wr && paddr == `PCS_A_CTRL) begin
         r_nxt.ctrl = pwdata[10:0];
      end
      if (wr && paddr == `PCS_A_IEN) begin
         r_nxt.ien = pwdata[5:0];
      end
      // A new event wins over a clear in the same cycle.
      r_nxt.istat = (r_r.istat & ~clr) | ev;

      // Read data and error are latched in the setup phase.
      if (setup) begin
         r_nxt.perr   = 1'b0;
         r_nxt.prdata = 32'h00000000;
         unique case (paddr)
            `PCS_A_CTRL: r_nxt.prdata[10:0] = r_r.ctrl;
            `PCS_A_STATUS: begin
               r_nxt.prdata[`PCS_S_PRESENT] = r_r.present;
               r_nxt.prdata[`PCS_S_READY] = ~io_mode & rdy_s;
               r_nxt.prdata[`PCS_S_BVD1] = ~io_mode & bvd1_s;
               r_nxt.prdata[`PCS_S_BVD2] = ~io_mode & bvd2_s;
               r_nxt.prdata[`PCS_S_VS1] = vs_s[0];
               r_nxt.prdata[`PCS_S_VS2] = vs_s[1];
               r_nxt.prdata[`PCS_S_BUSY] = (r_r.acc != pcs_pkg::PCS_IDLE);
               r_nxt.prdata[`PCS_S_WAIT] = wait_s;
               r_nxt.prdata[`PCS_S_CIRQ] = io_mode & ~rdy_s;
            end
            `PCS_A_ISTAT: r_nxt.prdata[5:0] = r_r.istat;
            `PCS_A_ICLR: r_nxt.prdata = 32'h00000000;
            `PCS_A_IEN: r_nxt.prdata[5:0] = r_r.ien;
            default: r_nxt.perr = 1'b1;
         endcase
      end

      // Card access cycle machine.
      r_nxt.done = 1'b0;
      unique case (r_r.acc)
         pcs_pkg::PCS_IDLE: begin
            if (acc_start) begin
               r_nxt.acc = pcs_pkg::PCS_STROBE;
               r_nxt.cnt = 4'(`PCS_STROBE_CYC - 1);
               r_nxt.a0  = acc_addr0;
               if (r_r.ctrl[`PCS_C_NARROW]) begin
                  // Narrow card: even lane only, address bit picks.
                  r_nxt.even_n = 1'b0;
                  r_nxt.odd_n  = 1'b1;
               end else begin
                  r_nxt.even_n = ~(acc_word | ~acc_addr0);
                  r_nxt.odd_n  = ~(acc_word | acc_addr0);
                  r_nxt.a0     = acc_addr0 & ~acc_word;
               end
            end
         end
         pcs_pkg::PCS_STROBE: begin
            if (r_r.cnt != 4'h0) begin
               r_nxt.cnt = r_r.cnt - 4'h1;
            end else if (!wait_s) begin
               // Wait released: end the cycle and raise the enables.
               r_nxt.acc    = pcs_pkg::PCS_IDLE;
               r_nxt.even_n = 1'b1;
               r_nxt.odd_n  = 1'b1;
               r_nxt.done   = 1'b1;
            end
         end
      endcase

      // Speaker and activity views of the second battery input.
      r_nxt.spk = io_mode & r_r.ctrl[`PCS_C_SPKEN] & ~bvd2_s;
      r_nxt.led = r_r.ctrl[`PCS_C_LEDEN] & ~bvd2_s;
      r_nxt.irq = |(r_nxt.istat & r_r.ien);
   end

   //***********************************************************
   // State register.
   //***********************************************************

   // Asynchronous reset loads constants only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_r        <= '0;
         r_r.s1     <= 8'hFF;
         r_r.s2     <= 8'hFF;
         r_r.rdy_q  <= 1'b1;
         r_r.bvd1_q <= 1'b1;
         r_r.ctrl   <= `PCS_CTRL_RST;
         r_r.ien    <= `PCS_IEN_RST;
         r_r.acc    <= pcs_pkg::PCS_IDLE;
         r_r.even_n <= 1'b1;
         r_r.odd_n  <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   //***********************************************************
   // Outputs.
   //***********************************************************

   // Bus answer; pready is a handshake and may be combinational.
   assign pready  = psel & penable;
   assign prdata  = r_r.prdata;
   assign pslverr = r_r.perr & psel & penable;
   assign irq     = r_r.irq;

   // Access handshake and card lane strobes.
   assign acc_busy           = (r_r.acc != pcs_pkg::PCS_IDLE);
   assign acc_done           = r_r.done;
   assign even_byte_enable_n = r_r.even_n;
   assign odd_byte_enable_n  = r_r.odd_n;
   assign lowest_address_bit = r_r.a0;

   // Reset floats until the card is seated, powered and enabled,
   // so a half-powered card never sees a reset glitch.
   assign card_reset_oe = r_r.present & r_r.ctrl[`PCS_C_POWER]
                          & r_r.ctrl[`PCS_C_IFEN];
   assign card_reset_out = card_reset_oe
                           & r_r.ctrl[`PCS_C_RESET];

   // Voltage sense pins double as strobes only when enabled; sense
   // readings are then meaningless.
   assign volt_sense_oe = r_r.ctrl[`PCS_C_GPEN];
   assign volt_sense_one_or_strobe_out = r_r.ctrl[`PCS_C_GP1];
   assign volt_sense_two_or_strobe_out = r_r.ctrl[`PCS_C_GP2];

   // Speaker and activity indicator.
   assign speaker_out  = r_r.spk;
   assign activity_out = r_r.led;

   //***********************************************************
   // Assertions.
   //***********************************************************

   // Narrow cards never see the odd lane strobe.
   property p_narrow_lane;
      @(posedge pclk) disable iff (!presetn)
      (r_r.acc == pcs_pkg::PCS_IDLE && acc_start
       && r_r.ctrl[`PCS_C_NARROW])
      |=> (!even_byte_enable_n && odd_byte_enable_n
           && lowest_address_bit == $past(acc_addr0));
   endproperty
   a_narrow_lane: assert property (p_narrow_lane)
      else $error("narrow access drove wrong lanes");

   // Wide word access drives both lanes for the strobe time.
   property p_word_lanes;
      @(posedge pclk) disable iff (!presetn)
      (r_r.acc == pcs_pkg::PCS_IDLE && acc_start && acc_word
       && !r_r.ctrl[`PCS_C_NARROW])
      |=> (!even_byte_enable_n && !odd_byte_enable_n) [*8];
   endproperty
   a_word_lanes: assert property (p_word_lanes)
      else $error("word access lanes not held low");

   // An idle machine keeps both lanes released.
   property p_idle_lanes;
      @(posedge pclk) disable iff (!presetn)
      !acc_busy |-> (even_byte_enable_n && odd_byte_enable_n);
   endproperty
   a_idle_lanes: assert property (p_idle_lanes)
      else $error("card enable low outside an access");

   // An active wait holds the cycle open.
   property p_wait_stall;
      @(posedge pclk) disable iff (!presetn)
      (acc_busy && r_r.cnt == 4'h0 && !r_r.s2[3])
      |=> (acc_busy && !acc_done);
   endproperty
   a_wait_stall: assert property (p_wait_stall)
      else $error("access ended while wait active");

   // No card means a floating reset pin.
   property p_reset_float;
      @(posedge pclk) disable iff (!presetn)
      !r_r.present |-> (!card_reset_oe && !card_reset_out);
   endproperty
   a_reset_float: assert property (p_reset_float)
      else $error("card reset driven with no card");

   // A driven reset follows the reset control bit.
   property p_reset_level;
      @(posedge pclk) disable iff (!presetn)
      card_reset_oe |-> (card_reset_out == r_r.ctrl[`PCS_C_RESET]);
   endproperty
   a_reset_level: assert property (p_reset_level)
      else $error("card reset level wrong");

   // Presence rises only after the detects were low.
   property p_present;
      @(posedge pclk) disable iff (!presetn)
      $rose(r_r.present) |-> $past(r_r.s2[1:0] == 2'h0);
   endproperty
   a_present: assert property (p_present)
      else $error("card present without both detects low");

   // An I/O mode card interrupt reaches the sticky bit.
   property p_card_irq;
      @(posedge pclk) disable iff (!presetn)
      (io_mode && !rdy_s) |=> r_r.istat[`PCS_E_CIRQ];
   endproperty
   a_card_irq: assert property (p_card_irq)
      else $error("card interrupt not latched");

   // With ring disabled, an I/O mode status change edge is latched as status change.
   property p_stschg;
      @(posedge pclk) disable iff (!presetn)
      (io_mode && r_r.bvd1_q && !bvd1_s && !clr[`PCS_E_STSCHG]
       && !r_r.ctrl[`PCS_C_RINGEN]) |=> r_r.istat[`PCS_E_STSCHG];
   endproperty
   a_stschg: assert property (p_stschg)
      else $error("status change not latched");

   // With ring enabled the same edge is a ring event.
   property p_ring;
      @(posedge pclk) disable iff (!presetn)
      (r_r.ctrl[`PCS_C_RINGEN] && r_r.bvd1_q && !bvd1_s)
      |=> (r_r.istat[`PCS_E_RING]);
   endproperty
   a_ring: assert property (p_ring)
      else $error("ring event not latched");

   // Strobes stop being driven in the cycle the enable falls.
   property p_gp_strobe;
      @(posedge pclk) disable iff (!presetn)
      $fell(r_r.ctrl[`PCS_C_GPEN]) |-> !volt_sense_oe;
   endproperty
   a_gp_strobe: assert property (p_gp_strobe)
      else $error("voltage sense pin driven while disabled");

endmodule

// ===== src/pcs_cfg.svh
// Register map, field positions, reset values and timing of the socket block.
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
// Byte offsets of the registers.
`define PCS_A_CTRL    8'h00
`define PCS_A_STATUS  8'h04
`define PCS_A_ISTAT   8'h08
`define PCS_A_ICLR    8'h0C
`define PCS_A_IEN     8'h10
// Control register fields.
`define PCS_C_IO      0
`define PCS_C_NARROW  1
`define PCS_C_RESET   2
`define PCS_C_POWER   3
`define PCS_C_IFEN    4
`define PCS_C_SPKEN   5
`define PCS_C_LEDEN   6
`define PCS_C_RINGEN  7
`define PCS_C_GPEN    8
`define PCS_C_GP1     9
`define PCS_C_GP2     10
`define PCS_CTRL_W    11
// Status register fields.
`define PCS_S_PRESENT 0
`define PCS_S_READY   1
`define PCS_S_BVD1    2
`define PCS_S_BVD2    3
`define PCS_S_VS1     4
`define PCS_S_VS2     5
`define PCS_S_BUSY    6
`define PCS_S_WAIT    7
`define PCS_S_CIRQ    8
// Interrupt event bits.
`define PCS_E_DETECT  0
`define PCS_E_READY   1
`define PCS_E_CIRQ    2
`define PCS_E_STSCHG  3
`define PCS_E_RING    4
`define PCS_E_DONE    5
`define PCS_EV_W      6
// Reset values.
`define PCS_CTRL_RST  11'h000
`define PCS_IEN_RST   6'h00
// Timing.
`define PCS_CLK_NS    40
`define PCS_STROBE_NS 300
`define PCS_STROBE_CYC ((`PCS_STROBE_NS+`PCS_CLK_NS-1)/`PCS_CLK_NS)
`define PCS_DEB_NS    10000000
`define PCS_DEB_CYC   ((`PCS_DEB_NS+`PCS_CLK_NS-1)/`PCS_CLK_NS)
`endif

// ===== src/pcs_pkg.sv
// Types shared by the socket signal control block.
package pcs_pkg;
   // Card access cycle phases.
   typedef enum logic [0:0] {
      PCS_IDLE,
      PCS_STROBE
   } pcs_acc_t;
   // Whole state of the block.
   typedef struct packed {
      logic [7:0]  s1;
      logic [7:0]  s2;
      logic [17:0] deb;
      logic        present;
      logic        rdy_q;
      logic        bvd1_q;
      logic [10:0] ctrl;
      logic [5:0]  istat;
      logic [5:0]  ien;
      logic [31:0] prdata;
      logic        perr;
      pcs_acc_t    acc;
      logic [3:0]  cnt;
      logic        even_n;
      logic        odd_n;
      logic        a0;
      logic        done;
      logic        spk;
      logic        led;
      logic        irq;
   } pcs_state_t;
endpackage

// ===== sim/pcs_card_model.sv
// Behavioural PC Card seated in the socket, seen from the host pins.
`timescale 1ns/1ps
module pcs_card_model (
   // Clock.
   input  wire logic       pclk,
   // Bench controls: detect contacts, line levels, grounded sense pins.
   input  wire logic [1:0] seat,
   input  wire logic [2:0] lv,
   input  wire logic [1:0] vsg,
   input  wire logic [3:0] wl,
   // Host outputs.
   input  wire logic       ce_even_n,
   input  wire logic       ce_odd_n,
   input  wire logic       vs1_o,
   input  wire logic       vs2_o,
   input  wire logic       vs_oe,
   // Card lines.
   output logic [1:0]      cd_n,
   output logic            rdy,
   output logic            wait_n,
   output logic            bvd1,
   output logic            bvd2,
   output logic            vs1,
   output logic            vs2
);
   int   cnt  = 0;
   logic ce_q = 1'b1;
   // Detect contacts are pulled up, so an empty contact reads high.
   assign cd_n = ~seat;
   assign rdy  = lv[0];
   assign bvd1 = lv[1];
   assign bvd2 = lv[2];
   // Sense pins are pulled up; card ground or host strobe pulls them low.
   assign vs1 = ~((vs_oe & ~vs1_o) | vsg[0]);
   assign vs2 = ~((vs_oe & ~vs2_o) | vsg[1]);
   // Wait is asserted one cycle after the enables fall and held wl cycles, then freed.
   always @(posedge pclk) begin
      ce_q <= ce_even_n & ce_odd_n;
      if (ce_q && !(ce_even_n & ce_odd_n)) begin
         cnt <= int'(wl);
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   assign wait_n = !(cnt > 0);
endmodule

// ===== sim/tb_top.sv
// Self-checking bench of the socket signal control block.
`timescale 1ns/1ps
module tb_top;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, rnd = 8'h40;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, irq, e, acc_busy, acc_done;
   logic        acc_start = 0, acc_word = 0, acc_addr0 = 0, ack_n = 1;
   logic        ce_e, ce_o, a0b, rst_o, rst_oe, rdy, wn, b1, b2;
   logic        vs1, vs2, vs1o, vs2o, vsoe, spk, act;
   logic [1:0]  cd_n, seat = 2'h0, vsg = 2'h0;
   logic [2:0]  lv = 3'h7;
   logic [3:0]  wl = 4'h0;
   int          err_total = 0, checked = 0, n;
   // The clock toggles every half period of 40 ns.
   always #20 pclk = ~pclk;
   pcs_socket #(.DEB_CYC(4)) pcs_socket_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .acc_start(acc_start), .acc_word(acc_word),
      .acc_addr0(acc_addr0), .acc_busy(acc_busy), .acc_done(acc_done),
      .even_byte_enable_n(ce_e), .odd_byte_enable_n(ce_o),
      .lowest_address_bit(a0b), .card_reset_out(rst_o),
      .card_reset_oe(rst_oe), .card_present_inputs_n(cd_n),
      .ready_or_card_irq(rdy), .card_wait_n(wn),
      .battery_dead_or_status_change(b1),
      .battery_warn_or_audio_or_activity(b2),
      .input_acknowledge_unused_n(ack_n),
      .volt_sense_one_or_strobe_in(vs1), .volt_sense_one_or_strobe_out(vs1o),
      .volt_sense_two_or_strobe_in(vs2), .volt_sense_two_or_strobe_out(vs2o),
      .volt_sense_oe(vsoe), .speaker_out(spk), .activity_out(act));
   pcs_card_model pcs_card_model_i (.pclk(pclk), .seat(seat), .lv(lv),
      .vsg(vsg), .wl(wl), .ce_even_n(ce_e), .ce_odd_n(ce_o), .vs1_o(vs1o),
      .vs2_o(vs2o), .vs_oe(vsoe), .cd_n(cd_n), .rdy(rdy), .wait_n(wn),
      .bvd1(b1), .bvd2(b2), .vs1(vs1), .vs2(vs2));
   //*************************************************************
   // Shared tasks
   //*************************************************************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Closing report: the only place the run ends.
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // One APB transfer; request held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
      if (k >= 50) begin
         err_total++;
         test_done();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
      apb(0, a, 32'h0);
      chk(q & m, x);
   endtask
   // Card access: lanes checked after the start edge, latency counted.
   task automatic access(input logic w, input logic a, input logic nar);
      @(posedge pclk);
      acc_start <= 1; acc_word <= w; acc_addr0 <= a;
      @(posedge pclk);
      acc_start <= 0;
      #1;
      chk({acc_busy, ce_e, ce_o, a0b}, nar ? {3'b101, a} :
          (w ? 4'b1000 : {1'b1, a, !a, a}));
      n = 0;
      while (acc_done !== 1'b1 && n < 200) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (n >= 200) begin
         err_total++;
         test_done();
      end
   endtask
   // Main sequence.
   initial begin
      cyc(10);
      presetn <= 1;
      rd(8'h00, 32'hFFFFFFFF, 32'h0);
      rd(8'h10, 32'hFFFFFFFF, 32'h0);
      rd(8'h14, 32'hFFFFFFFF, 32'h0);
      chk(e, 1);
      apb(1, 8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'hFFFFFFFF, 32'h3F);
      $display("test registers done");
      seat <= 2'b01;
      cyc(20);
      rd(8'h04, 32'h1, 32'h0);
      seat <= 2'b11;
      cyc(20);
      rd(8'h04, 32'h1, 32'h1);
      rd(8'h08, 32'h1, 32'h1);
      chk(irq, 1);
      apb(1, 8'h0C, 32'h3F);
      cyc(3);
      chk(irq, 0);
      $display("test presence done");
      apb(1, 8'h00, 32'h18);
      cyc(1);
      chk({rst_oe, rst_o}, 2'b10);
      apb(1, 8'h00, 32'h1C);
      cyc(1);
      chk({rst_oe, rst_o}, 2'b11);
      apb(1, 8'h00, 32'h14);
      cyc(1);
      chk({rst_oe, rst_o}, 2'b00);
      $display("test card reset done");
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         lv <= rnd[2:0]; vsg <= rnd[4:3]; ack_n <= rnd[6];
         apb(1, 8'h00, {31'h0, rnd[5]});
         cyc(6);
         rd(8'h04, 32'h1FF, {7'h0, rnd[5] & !rnd[0], 2'h0, ~rnd[4:3],
            rnd[5] ? 3'h0 : rnd[2:0], 1'b1});
      end
      $display("test status done");
      lv <= 3'h6;
      vsg <= 2'h0;
      apb(1, 8'h00, 32'h0);
      cyc(6);
      apb(1, 8'h0C, 32'h3F);
      lv <= 3'h7;
      cyc(6);
      rd(8'h08, 32'h2, 32'h2);
      apb(1, 8'h00, 32'h1);
      cyc(6);
      apb(1, 8'h0C, 32'h3F);
      lv <= 3'h5;
      cyc(6);
      rd(8'h08, 32'h18, 32'h08);
      lv <= 3'h7;
      apb(1, 8'h00, 32'h81);
      cyc(6);
      apb(1, 8'h0C, 32'h3F);
      lv <= 3'h5;
      cyc(6);
      rd(8'h08, 32'h18, 32'h10);
      $display("test status change done");
      apb(1, 8'h00, 32'h21);
      lv <= 3'h3;
      cyc(6);
      chk({spk, act}, 2'b10);
      apb(1, 8'h00, 32'h40);
      cyc(3);
      chk({spk, act}, 2'b01);
      lv <= 3'h7;
      for (int k = 0; k < 4; k++) begin
         apb(1, 8'h00, 32'h100 | (k << 9));
         cyc(1);
         chk({vsoe, vs2o, vs1o, vs2, vs1}, {1'b1, k[1:0], k[1:0]});
      end
      $display("test strobes done");
      for (int m = 0; m < 8; m++) begin
         apb(1, 8'h00, {30'h0, m[2], 1'b0});
         apb(1, 8'h0C, 32'h3F);
         access(m[1], m[0], m[2]);
         chk(n, 8);
         cyc(1);
         rd(8'h08, 32'h20, 32'h20);
      end
      apb(1, 8'h00, 32'h0);
      wl <= 4'hC;
      access(1, 0, 0);
      chk(n > 9 && n < 30, 1);
      $display("test access done");
      test_done();
   end
endmodule
